// File: verilog/clc_pkg.sv
package clc_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int WAKE_TIME_US = 4;
  localparam int WAKE_CYC = (WAKE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WAKE_W = 10;
  localparam logic [3:0] SRST_STABLE = 4'h8;
  localparam int FLUSH_LINES = 256;
  localparam logic [7:0] FLUSH_LAST = 8'hff;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] FILLS_OFS = 8'h08;
  localparam int CTRL_FORCE_WT_BIT = 0;
  localparam int CTRL_MISS_INH_BIT = 1;
  localparam int CTRL_FLUSH_BIT = 2;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // ----------------------------------------
  // test port
  // ----------------------------------------
  localparam logic [3:0] IR_IDCODE = 4'h1;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  // arbitrary identity value, bit 0 set as the test port demands
  localparam logic [31:0] ID_VALUE = 32'h00000001;

  typedef enum logic [3:0] {
    CLC_IDLE, CLC_DECIDE, CLC_FILL, CLC_FLUSH, CLC_FLUSH_WB, CLC_LOWPWR, CLC_WAKE
  } clc_dstate_t;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR,
    TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
  } clc_tap_t;

  typedef struct packed {
    logic miss_fill_inhibit;
    logic tag_clear;
    logic update_inhibit;
    logic low_power_request;
    logic soft_reset;
    logic write_through_status;
    logic flush_request;
  } clc_ctl_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } clc_jtag_t;

  typedef struct packed {
    logic start_n;
    logic burst_n;
    logic inhibit_n;
    logic error_n;
    logic write;
    logic tag_hit;
    logic fill_done;
    logic line_dirty;
    logic wb_done;
  } clc_bus_t;

  typedef struct packed {
    logic fill_start;
    logic claim;
    logic mark_dirty;
    logic line_inval;
    logic wb_start;
    logic inval_all;
    logic array_gate;
    logic [7:0] flush_index;
  } clc_cmd_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } clc_ahb_req_t;

endpackage

// File: verilog/clc_control.sv
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module clc_control (
  input wire logic clk,
  input wire logic reset,
  input wire clc_pkg::clc_ahb_req_t ahb,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire clc_pkg::clc_ctl_t ctl,
  input wire clc_pkg::clc_bus_t bus,
  output clc_pkg::clc_cmd_t cmd,
  input wire clc_pkg::clc_jtag_t jtag,
  output logic tdo,
  output logic tdo_oe_n
);

  typedef struct packed {
    clc_pkg::clc_ctl_t ctl_s1;
    clc_pkg::clc_ctl_t ctl_s2;
    clc_pkg::clc_jtag_t jt_s1;
    clc_pkg::clc_jtag_t jt_s2;
    logic tck_d;
    logic [3:0] srst_cnt;
    logic srst_act;
    clc_pkg::clc_dstate_t dst;
    logic burst;
    logic write;
    logic [clc_pkg::WAKE_W-1:0] wake_cnt;
    logic [7:0] flush_idx;
    logic [15:0] fills;
    logic force_wt;
    logic sw_miss_inh;
    logic sw_flush;
    logic a_wr;
    logic [7:0] a_ofs;
    logic [31:0] rdata;
    clc_pkg::clc_cmd_t cmd;
    clc_pkg::clc_tap_t tap;
    logic [3:0] ir;
    logic [3:0] ir_sh;
    logic [31:0] dr_sh;
    logic tdo;
  } clc_state_t;

  clc_state_t st_r;
  clc_state_t st_nxt;

  localparam logic [clc_pkg::WAKE_W-1:0] WAKE_LOAD = clc_pkg::WAKE_W'(clc_pkg::WAKE_CYC - 1);

  logic wt_mode;
  logic miss_inh;
  logic ts;
  logic tck_rise;
  logic tck_fall;
  logic [31:0] status;

  assign wt_mode = ~st_r.ctl_s2.write_through_status | st_r.force_wt;
  assign miss_inh = st_r.ctl_s2.miss_fill_inhibit | st_r.sw_miss_inh;
  assign ts = ~bus.start_n;
  assign tck_rise = st_r.jt_s2.tck & ~st_r.tck_d;
  assign tck_fall = ~st_r.jt_s2.tck & st_r.tck_d;
  assign status = {22'h0, st_r.srst_act, st_r.ctl_s2.update_inhibit, st_r.ctl_s2.tag_clear,
                   st_r.ctl_s2.low_power_request, st_r.dst == clc_pkg::CLC_WAKE, wt_mode, 4'(st_r.dst)};

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign cmd = st_r.cmd;
  assign tdo = st_r.tdo;
  assign tdo_oe_n = ~(st_r.tap == clc_pkg::TAP_SH_DR || st_r.tap == clc_pkg::TAP_SH_IR);

  always_comb begin
    st_nxt = st_r;

    // ----------------------------------------
    // synchronisers
    // ----------------------------------------
    // stage one feeds stage two only
    st_nxt.ctl_s1 = ctl;
    st_nxt.ctl_s2 = st_r.ctl_s1;
    st_nxt.jt_s1 = jtag;
    st_nxt.jt_s2 = st_r.jt_s1;
    st_nxt.tck_d = st_r.jt_s2.tck;

    // two sync stages plus eight stable cycles lands inside 8..16
    if (!st_r.ctl_s2.soft_reset) begin
      st_nxt.srst_cnt = 4'h0;
      st_nxt.srst_act = 1'b0;
    end else if (st_r.srst_cnt != clc_pkg::SRST_STABLE) begin
      st_nxt.srst_cnt = st_r.srst_cnt + 4'h1;
    end else begin
      st_nxt.srst_act = 1'b1;
    end

    // ----------------------------------------
    // register slave
    // ----------------------------------------
    st_nxt.sw_flush = 1'b0;
    if (st_r.a_wr) begin
      if (st_r.a_ofs == clc_pkg::CTRL_OFS) begin
        st_nxt.force_wt = ahb.hwdata[clc_pkg::CTRL_FORCE_WT_BIT];
        st_nxt.sw_miss_inh = ahb.hwdata[clc_pkg::CTRL_MISS_INH_BIT];
        st_nxt.sw_flush = ahb.hwdata[clc_pkg::CTRL_FLUSH_BIT];
      end
    end
    st_nxt.a_wr = 1'b0;
    if (ahb.hsel && ahb.hready && ahb.htrans[1]) begin
      st_nxt.a_wr = ahb.hwrite;
      st_nxt.a_ofs = ahb.haddr[7:0];
      if (ahb.haddr[31:8] != 24'h0) begin
        st_nxt.rdata = 32'h0;
        st_nxt.a_wr = 1'b0;
      end else if (ahb.haddr[7:0] == clc_pkg::CTRL_OFS) begin
        st_nxt.rdata = {29'h0, 1'b0, st_r.sw_miss_inh, st_r.force_wt};
      end else if (ahb.haddr[7:0] == clc_pkg::STATUS_OFS) begin
        st_nxt.rdata = status;
      end else if (ahb.haddr[7:0] == clc_pkg::FILLS_OFS) begin
        st_nxt.rdata = {16'h0, st_r.fills};
      end else begin
        st_nxt.rdata = 32'h0;
      end
    end

    // ----------------------------------------
    // cache control
    // ----------------------------------------
    st_nxt.cmd.fill_start = 1'b0;
    st_nxt.cmd.claim = 1'b0;
    st_nxt.cmd.mark_dirty = 1'b0;
    st_nxt.cmd.line_inval = 1'b0;
    st_nxt.cmd.wb_start = 1'b0;
    st_nxt.cmd.inval_all = 1'b0;

    if (st_r.ctl_s2.tag_clear) begin
      // held in reset for as long as the input stays up
      st_nxt.cmd.inval_all = 1'b1;
      st_nxt.dst = clc_pkg::CLC_IDLE;
      st_nxt.flush_idx = 8'h0;
      st_nxt.cmd.array_gate = 1'b0;
    end else if (st_r.ctl_s2.update_inhibit) begin
      // everything cache-side stays as it was; bus is not watched
      st_nxt.cmd = st_r.cmd;
      st_nxt.sw_flush = st_r.sw_flush | st_nxt.sw_flush;
    end else if (st_r.ctl_s2.low_power_request) begin
      // clock will be stopped outside; freeze array ports first
      st_nxt.dst = clc_pkg::CLC_LOWPWR;
      st_nxt.cmd.array_gate = 1'b1;
      st_nxt.wake_cnt = WAKE_LOAD;
    end else if (st_r.dst == clc_pkg::CLC_LOWPWR) begin
      st_nxt.dst = clc_pkg::CLC_WAKE;
    end else if (st_r.dst == clc_pkg::CLC_WAKE) begin
      // no answer to the bus until the full wake time is spent
      if (st_r.wake_cnt == '0) begin
        st_nxt.dst = clc_pkg::CLC_IDLE;
        st_nxt.cmd.array_gate = 1'b0;
      end else begin
        st_nxt.wake_cnt = st_r.wake_cnt - 1'b1;
      end
    end else if (st_r.srst_act) begin
      st_nxt.dst = clc_pkg::CLC_IDLE;
    end else begin
      case (st_r.dst)
        clc_pkg::CLC_IDLE: begin
          if (ts) begin
            st_nxt.burst = ~bus.burst_n;
            st_nxt.write = bus.write;
            st_nxt.dst = clc_pkg::CLC_DECIDE;
          end else if (st_r.ctl_s2.flush_request || st_r.sw_flush) begin
            st_nxt.flush_idx = 8'h0;
            st_nxt.dst = clc_pkg::CLC_FLUSH;
          end
        end
        clc_pkg::CLC_DECIDE: begin
          st_nxt.dst = clc_pkg::CLC_IDLE;
          if (!bus.error_n) begin
            st_nxt.dst = clc_pkg::CLC_IDLE;
          end else if (bus.tag_hit) begin
            if (!st_r.burst) begin
              st_nxt.cmd.line_inval = 1'b1;
            end else if (st_r.write) begin
              st_nxt.cmd.mark_dirty = ~wt_mode;
            end else begin
              st_nxt.cmd.claim = 1'b1;
            end
          end else if (st_r.burst && bus.inhibit_n && !miss_inh) begin
            st_nxt.cmd.fill_start = 1'b1;
            st_nxt.fills = st_r.fills + 16'h1;
            st_nxt.dst = clc_pkg::CLC_FILL;
          end
        end
        clc_pkg::CLC_FILL: begin
          if (bus.fill_done || !bus.error_n) begin
            st_nxt.dst = clc_pkg::CLC_IDLE;
          end
        end
        clc_pkg::CLC_FLUSH: begin
          if (bus.line_dirty && !wt_mode) begin
            st_nxt.cmd.wb_start = 1'b1;
            st_nxt.dst = clc_pkg::CLC_FLUSH_WB;
          end else if (st_r.flush_idx == clc_pkg::FLUSH_LAST) begin
            st_nxt.cmd.inval_all = 1'b1;
            st_nxt.dst = clc_pkg::CLC_IDLE;
          end else begin
            st_nxt.flush_idx = st_r.flush_idx + 8'h1;
          end
        end
        clc_pkg::CLC_FLUSH_WB: begin
          if (bus.wb_done) begin
            if (st_r.flush_idx == clc_pkg::FLUSH_LAST) begin
              st_nxt.cmd.inval_all = 1'b1;
              st_nxt.dst = clc_pkg::CLC_IDLE;
            end else begin
              st_nxt.flush_idx = st_r.flush_idx + 8'h1;
              st_nxt.dst = clc_pkg::CLC_FLUSH;
            end
          end
        end
        default: begin
          st_nxt.dst = clc_pkg::CLC_IDLE;
        end
      endcase
    end
    st_nxt.cmd.flush_index = st_nxt.flush_idx;

    // ----------------------------------------
    // test port, stepped on synchronised test clock edges
    // ----------------------------------------
    if (!st_r.jt_s2.trst_n) begin
      st_nxt.tap = clc_pkg::TAP_RESET;
      st_nxt.ir = clc_pkg::IR_IDCODE;
    end else if (tck_rise) begin
      case (st_r.tap)
        clc_pkg::TAP_CAP_DR: begin
          st_nxt.dr_sh = (st_r.ir == clc_pkg::IR_IDCODE) ? clc_pkg::ID_VALUE : 32'h0;
        end
        clc_pkg::TAP_SH_DR: begin
          if (st_r.ir == clc_pkg::IR_IDCODE) begin
            st_nxt.dr_sh = {st_r.jt_s2.tdi, st_r.dr_sh[31:1]};
          end else begin
            st_nxt.dr_sh = {31'h0, st_r.jt_s2.tdi};
          end
        end
        clc_pkg::TAP_CAP_IR: begin
          st_nxt.ir_sh = {2'h0, clc_pkg::IR_CAPTURE};
        end
        clc_pkg::TAP_SH_IR: begin
          st_nxt.ir_sh = {st_r.jt_s2.tdi, st_r.ir_sh[3:1]};
        end
        clc_pkg::TAP_UPD_IR: begin
          st_nxt.ir = st_r.ir_sh;
        end
        clc_pkg::TAP_RESET: begin
          st_nxt.ir = clc_pkg::IR_IDCODE;
        end
        default: begin
        end
      endcase
      case (st_r.tap)
        clc_pkg::TAP_RESET: st_nxt.tap = st_r.jt_s2.tms ? clc_pkg::TAP_RESET : clc_pkg::TAP_IDLE;
        clc_pkg::TAP_IDLE: st_nxt.tap = st_r.jt_s2.tms ? clc_pkg::TAP_SEL_DR : clc_pkg::TAP_IDLE;
        clc_pkg::TAP_SEL_DR: st_nxt.tap = st_r.jt_s2.tms ? clc_pkg::TAP_SEL_IR : clc_pkg::TAP_CAP_DR;
        clc_pkg::TAP_CAP_DR: st_nxt.tap = st_r.jt_s2.tms ? clc_pkg::TAP_EX1_DR : clc_pkg::TAP_SH_DR;
        clc_pkg::TAP_SH_DR: st_nxt.tap = st_r.jt_s2.tms ? clc_pkg::TAP_EX1_DR : clc_pkg::TAP_SH_DR;
        clc_pkg::TAP_EX1_DR: st_nxt.tap = st_r.jt_s2.tms ? clc_pkg::TAP_UPD_DR : clc_pkg::TAP_PAU_DR;
        clc_pkg::TAP_PAU_DR: st_nxt.tap = st_r.jt_s2.tms ? clc_pkg::TAP_EX2_DR : clc_pkg::TAP_PAU_DR;
        clc_pkg::TAP_EX2_DR: st_nxt.tap = st_r.jt_s2.tms ? clc_pkg::TAP_UPD_DR : clc_pkg::TAP_SH_DR;
        clc_pkg::TAP_UPD_DR: st_nxt.tap = st_r.jt_s2.tms ? clc_pkg::TAP_SEL_DR : clc_pkg::TAP_IDLE;
        clc_pkg::TAP_SEL_IR: st_nxt.tap = st_r.jt_s2.tms ? clc_pkg::TAP_RESET : clc_pkg::TAP_CAP_IR;
        clc_pkg::TAP_CAP_IR: st_nxt.tap = st_r.jt_s2.tms ? clc_pkg::TAP_EX1_IR : clc_pkg::TAP_SH_IR;
        clc_pkg::TAP_SH_IR: st_nxt.tap = st_r.jt_s2.tms ? clc_pkg::TAP_EX1_IR : clc_pkg::TAP_SH_IR;
        clc_pkg::TAP_EX1_IR: st_nxt.tap = st_r.jt_s2.tms ? clc_pkg::TAP_UPD_IR : clc_pkg::TAP_PAU_IR;
        clc_pkg::TAP_PAU_IR: st_nxt.tap = st_r.jt_s2.tms ? clc_pkg::TAP_EX2_IR : clc_pkg::TAP_PAU_IR;
        clc_pkg::TAP_EX2_IR: st_nxt.tap = st_r.jt_s2.tms ? clc_pkg::TAP_UPD_IR : clc_pkg::TAP_SH_IR;
        default: st_nxt.tap = st_r.jt_s2.tms ? clc_pkg::TAP_SEL_DR : clc_pkg::TAP_IDLE;
      endcase
    end else if (tck_fall) begin
      // output moves on the falling test clock edge
      if (st_r.tap == clc_pkg::TAP_SH_IR) begin
        st_nxt.tdo = st_r.ir_sh[0];
      end else if (st_r.tap == clc_pkg::TAP_SH_DR) begin
        st_nxt.tdo = st_r.dr_sh[0];
      end
    end
  end

  // reset values are all zero: idle, reset tap, no commands
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// File: test/clc_chk.sv
`timescale 1ns/10ps
module clc_chk (
  input wire logic clk,
  input wire logic reset,
  input wire clc_pkg::clc_ahb_req_t ahb,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire clc_pkg::clc_ctl_t ctl,
  input wire clc_pkg::clc_bus_t bus,
  input wire clc_pkg::clc_cmd_t cmd,
  input wire clc_pkg::clc_jtag_t jtag,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  logic [9:0] wk_r;
  logic act;
  assign act = cmd.fill_start | cmd.claim | cmd.mark_dirty | cmd.line_inval;
  // ----------------------------------------
  // wake window: 1 while held, then one more for each edge since release
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      wk_r <= 10'h000;
    end else if (ctl.low_power_request) begin
      wk_r <= 10'h001;
    end else if (wk_r != 10'h000 && wk_r != 10'h3ff) begin
      wk_r <= wk_r + 10'h001;
    end
  end
  AST_MISS_INH: assert property (ctl.miss_fill_inhibit[*6] |-> !cmd.fill_start)
    else $error("fill under miss inhibit");
  AST_TAG_CLR: assert property (ctl.tag_clear[*4] |-> cmd.inval_all && !act)
    else $error("tag clear not holding reset");
  AST_UPD_FREEZE: assert property ((ctl.update_inhibit && !ctl.tag_clear)[*4] |=> $stable(cmd))
    else $error("state moved under update inhibit");
  AST_LP_GATE: assert property ((ctl.low_power_request && !ctl.update_inhibit && !ctl.tag_clear)[*4] |-> cmd.array_gate)
    else $error("array not gated in low power");
  AST_WAKE_QUIET: assert property ((wk_r > 10'h001 && wk_r < 10'(clc_pkg::WAKE_CYC)) |-> cmd.array_gate && !act)
    else $error("activity during wake time");
  AST_WAKE_END: assert property (wk_r == 10'h3ff |-> !cmd.array_gate)
    else $error("array still gated long after wake");
  AST_SRST_IDLE: assert property (ctl.soft_reset[*8] ##1 ctl.soft_reset[*8] |-> !act)
    else $error("activity under soft reset");
  AST_WT_ONLY: assert property ((!ctl.write_through_status)[*4] |-> !cmd.mark_dirty && !cmd.wb_start)
    else $error("dirty or copy-back in write-through");
  AST_START: assert property ((cmd.claim || cmd.fill_start) |->
    (!$past(bus.start_n, 2) && !$past(bus.burst_n, 2)) || (!$past(bus.start_n, 3) && !$past(bus.burst_n, 3)))
    else $error("claim or fill without burst start");
  AST_TAP_RESET: assert property ((!jtag.trst_n)[*4] |-> tdo_oe_n)
    else $error("test output driven in tap reset");
endmodule
bind clc_control clc_chk u_chk (.clk(clk), .reset(reset), .ahb(ahb), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .ctl(ctl), .bus(bus), .cmd(cmd), .jtag(jtag), .tdo(tdo), .tdo_oe_n(tdo_oe_n));

// File: test/clc_bus_model.sv
`timescale 1ns/10ps
module clc_bus_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [4:0] attr,
  input wire logic [7:0] lat,
  input wire clc_pkg::clc_cmd_t cmd,
  output clc_pkg::clc_bus_t bus
);
  // ----------------------------------------
  // far master: attr is burst_n, write, tag_hit, inhibit_n, error_n
  // ----------------------------------------
  clc_pkg::clc_bus_t b_r = 9'h1e0;
  int fw = 0;
  int ww = 0;
  // dirty flag follows the walked line with no lag
  assign bus = {b_r[8:2], cmd.flush_index[5:0] == 6'h00, b_r[0]};
  always @(posedge clk) begin
    b_r.start_n <= !go;
    b_r.burst_n <= go ? attr[4] : !b_r.burst_n;
    b_r.write <= go ? attr[3] : !b_r.write;
    b_r.tag_hit <= !b_r.start_n ? attr[2] : !b_r.tag_hit;
    b_r.inhibit_n <= !b_r.start_n ? attr[1] : 1'b1;
    b_r.error_n <= !b_r.start_n ? attr[0] : 1'b1;
    b_r.fill_done <= fw == 1;
    b_r.wb_done <= ww == 1;
    // zero latency means the fill is never answered
    fw <= cmd.fill_start ? int'(lat) : (fw > 0 ? fw - 1 : 0);
    ww <= cmd.wb_start ? 3 : (ww > 0 ? ww - 1 : 0);
  end
endmodule

// File: test/tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin n_mismatch++; $display("BAD %s exp %h got %h", nm, e, s); end end
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  clc_pkg::clc_ahb_req_t ahb = '{hready: 1'b1, default: '0};
  clc_pkg::clc_ctl_t ctl = 7'h02;
  clc_pkg::clc_jtag_t jtag = 4'h0;
  clc_pkg::clc_bus_t bus;
  clc_pkg::clc_cmd_t cmd;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic go = 1'b0;
  logic [4:0] attr = 5'h1f;
  logic [7:0] lat = 8'h01;
  logic [31:0] rd;
  int n_mismatch = 0;
  int compares = 0;
  int pc[6] = '{default: 0};
  logic [4:0] at_t[7] = '{5'h07, 5'h0f, 5'h17, 5'h03, 5'h13, 5'h01, 5'h02};
  int ex_t[7] = '{1, 2, 3, 0, -1, -1, -1};
  wire [5:0] pv = {cmd.inval_all, cmd.wb_start, cmd.line_inval, cmd.mark_dirty, cmd.claim, cmd.fill_start};
  logic tdo;
  logic tdo_oe_n;
  logic [31:0] id;
  logic clk_on = 1'b1;
  // stops low only when the system parks the clock for low power
  always #2.5 clk = (clk_on || clk) ? ~clk : clk;
  clc_control u_dut (.clk(clk), .reset(reset), .ahb(ahb), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ctl(ctl), .bus(bus), .cmd(cmd), .jtag(jtag), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
  clc_bus_model u_far (.clk(clk), .go(go), .attr(attr), .lat(lat), .cmd(cmd), .bus(bus));
  always @(posedge clk) begin
    for (int i = 0; i < 6; i++) begin
      pc[i] <= pc[i] + int'(pv[i]);
    end
  end
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    ahb.hsel <= 1'b1;
    ahb.htrans <= 2'h2;
    ahb.haddr <= {24'h000000, a};
    ahb.hwrite <= w;
    ahb.hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    ahb.htrans <= 2'h0;
    ahb.hsel <= 1'b0;
    ahb.hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK("resp", 1'b0, hresp)
  endtask
  // k is the pulse expected from the start, -1 for none; inval_all is not counted
  task automatic op(input logic [4:0] at, input int k);
    int b[6];
    b = pc;
    attr <= at;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (12) @(posedge clk);
    for (int i = 0; i < 5; i++) `CHK("pulse", (i == k) ? 1 : 0, pc[i] - b[i])
  endtask
  // test clock slow enough for the two-stage synchroniser
  task automatic tk(input logic ms, input logic di);
    jtag.tms <= ms;
    jtag.tdi <= di;
    repeat (4) @(posedge clk);
    jtag.tck <= 1'b1;
    repeat (4) @(posedge clk);
    jtag.tck <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic fl(input int nwb, input logic sw);
    int b[6];
    b = pc;
    if (sw) begin
      xfer(1'b1, clc_pkg::CTRL_OFS, 32'h4);
    end else begin
      ctl.flush_request <= 1'b1;
      repeat (4) @(posedge clk);
      ctl.flush_request <= 1'b0;
    end
    for (int t = 0; t < 2000 && pc[5] == b[5]; t++) @(posedge clk);
    `CHK("wb", nwb, pc[4] - b[4])
    `CHK("inval", 1, pc[5] - b[5])
  endtask
  task automatic tally_and_finish();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    jtag.trst_n <= 1'b1;
    repeat (4) @(posedge clk);
    tk(1'b0, 1'b0);
    tk(1'b1, 1'b0);
    tk(1'b0, 1'b0);
    tk(1'b0, 1'b0);
    `CHK("tdo_oe_n", 1'b0, tdo_oe_n)
    for (int i = 0; i < 32; i++) begin
      id[i] = tdo;
      tk(1'b0, 1'b0);
    end
    `CHK("idcode", clc_pkg::ID_VALUE, id)
    jtag.trst_n <= 1'b0;
    repeat (4) @(posedge clk);
    xfer(1'b0, clc_pkg::CTRL_OFS, 32'h0);
    `CHK("ctrl", {30'h0, clc_pkg::CTRL_RESET}, rd)
    xfer(1'b1, clc_pkg::CTRL_OFS, 32'h3);
    xfer(1'b0, clc_pkg::CTRL_OFS, 32'h0);
    `CHK("ctrl", 32'h3, rd)
    op(5'h03, -1);
    op(5'h0f, -1);
    xfer(1'b1, clc_pkg::CTRL_OFS, 32'h0);
    xfer(1'b0, 8'h0c, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    for (int i = 0; i < 7; i++) op(at_t[i], ex_t[i]);
    xfer(1'b0, clc_pkg::FILLS_OFS, 32'h0);
    `CHK("fills", 32'h1, rd)
    ctl.miss_fill_inhibit <= 1'b1;
    repeat (3) @(posedge clk);
    op(5'h03, -1);
    ctl.miss_fill_inhibit <= 1'b0;
    ctl.write_through_status <= 1'b0;
    repeat (3) @(posedge clk);
    op(5'h0f, -1);
    fl(0, 1'b0);
    ctl.write_through_status <= 1'b1;
    repeat (3) @(posedge clk);
    fl(clc_pkg::FLUSH_LINES / 64, 1'b0);
    fl(clc_pkg::FLUSH_LINES / 64, 1'b1);
    ctl.tag_clear <= 1'b1;
    ctl.update_inhibit <= 1'b1;
    ctl.miss_fill_inhibit <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("tagclr", 1'b1, cmd.inval_all)
    op(5'h07, -1);
    ctl.update_inhibit <= 1'b0;
    ctl.miss_fill_inhibit <= 1'b0;
    op(5'h07, -1);
    ctl.tag_clear <= 1'b0;
    ctl.update_inhibit <= 1'b1;
    repeat (3) @(posedge clk);
    op(5'h07, -1);
    ctl.update_inhibit <= 1'b0;
    ctl.low_power_request <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK("gate", 1'b1, cmd.array_gate)
    xfer(1'b0, clc_pkg::STATUS_OFS, 32'h0);
    `CHK("status", 32'h45, rd)
    clk_on = 1'b0;
    #100;
    clk_on = 1'b1;
    @(posedge clk);
    ctl.low_power_request <= 1'b0;
    repeat (200) @(posedge clk);
    op(5'h07, -1);
    repeat (clc_pkg::WAKE_CYC) @(posedge clk);
    op(5'h07, 1);
    lat <= 8'h00;
    op(5'h03, 0);
    op(5'h07, -1);
    ctl.soft_reset <= 1'b1;
    repeat (20) @(posedge clk);
    ctl.soft_reset <= 1'b0;
    lat <= 8'h01;
    repeat (3) @(posedge clk);
    op(5'h07, 1);
    tally_and_finish();
  end
  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
